// ==== common/snr_pkg.sv ====
// shared constants and types of the serial normal read block
package snr_pkg;

  localparam int unsigned ARRAY_AW     = 25;  // 256 Mbit array, byte addressed
  localparam int unsigned FIFO_WORDS   = 32;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned SCK_MAX_MHZ  = 80;  // highest serial clock for this read

  localparam logic [7:0]  OP_READ      = 8'h03;
  localparam logic [7:0]  OP_READ_WIDE = 8'h13;

  localparam logic [5:0]  OPCODE_LAST  = 6'h07;
  localparam logic [5:0]  ADDR_LAST_3B = 6'h17;
  localparam logic [5:0]  ADDR_LAST_4B = 6'h1f;
  localparam logic [2:0]  BYTE_LAST    = 3'h7;
  localparam logic [2:0]  BIT_STEP     = 3'h1;
  localparam logic [5:0]  CNT_STEP     = 6'h01;

  localparam logic [31:0] ADDR_MASK_3B = 32'h00ff_ffff;
  localparam logic [31:0] ADDR_MASK_4B = 32'h01ff_ffff;

  typedef enum logic [3:0] {
    SNR_OPCODE = 4'b0001,
    SNR_ADDR   = 4'b0010,
    SNR_DATA   = 4'b0100,
    SNR_IGNORE = 4'b1000
  } snr_state_t;

endpackage

// ==== rtl/snr_array_mem.sv ====
// byte array: written on the system clock, read on the serial clock
`timescale 1ns/100ps
`default_nettype none

module snr_array_mem #(
  parameter int unsigned DW = 8,
  parameter int unsigned AW = 25
) (
  input  wire logic          wclk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          rclk_i,
  input  wire logic          re_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_reg [0:(1<<AW)-1];
  logic [DW-1:0] rdata_reg;

  always_ff @(posedge wclk_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  // registered read keeps the serial path to one memory access per edge
  always_ff @(posedge rclk_i) begin
    if (re_i) begin
      rdata_reg <= mem_reg[raddr_i];
    end
  end

  assign rdata_o = rdata_reg;

endmodule

`default_nettype wire

// ==== rtl/snr_fifo.sv ====
// single clock fifo with registered ready and valid
`timescale 1ns/100ps
`default_nettype none

module snr_fifo #(
  parameter int unsigned WIDTH = 33,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] buf_reg [0:DEPTH-1];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic [CW-1:0]    count_next;
  logic             push;
  logic             pop;

  assign push       = in_valid_i && in_ready_o;
  assign pop        = out_valid_o && out_ready_i;
  assign out_data_o = buf_reg[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + CW'(1);
    end else if (pop && !push) begin
      count_next = count_reg - CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      buf_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      count_reg   <= '0;
      in_ready_o  <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      count_reg   <= count_next;
      in_ready_o  <= (count_next != CW'(DEPTH));
      out_valid_o <= (count_next != '0);
    end
  end

endmodule

`default_nettype wire

// ==== rtl/snr_normal_read.sv ====
// serial flash normal read path: spi link, byte array and load fifo
// Notes on behaviour
// [R01] normal read runs on the serial clock up to 80 MHz, opcodes 03h and 13h
// [R02] 03h takes three or four address bytes per mode bit; 13h always four
// [R03] host sends opcode then address bytes serially on the data input
// [R04] all 24 or 32 address bits shift in; bits above valid msb ignored
// [R05] three byte mode decodes bits 23..0; four byte mode bits 24..0
// [R06] after the last address bit the data input is ignored
// [R07] each byte goes out msb first, starting at the received address
// [R08] address steps by one after every byte, reading on without limit
// [R09] past the top location the address wraps to zero and streaming goes on
// [R10] chip select high ends the read and stops output
// [R11] a read arriving during write or erase is ignored, work undisturbed; pending array writes still wait while selected
// [R12] inputs sampled on rising serial clock, output changes on falling edge
// [R13] chip select high before the address completes aborts without effect
`timescale 1ns/100ps
`default_nettype none

module snr_normal_read
  import snr_pkg::*;
#(
  parameter int unsigned AW    = ARRAY_AW,
  parameter int unsigned DEPTH = FIFO_WORDS
) (
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  input  wire logic          load_valid_i,
  output logic               load_ready_o,
  input  wire logic [AW-1:0] load_addr_i,
  input  wire logic [7:0]    load_data_i,
  input  wire logic          array_busy_i,
  input  wire logic          extended_address_mode_bit_i,
  output logic               write_in_progress_flag_o,
  output logic               read_start_o,
  output logic      [AW-1:0] read_addr_o,
  output logic               read_ignored_o,
  input  wire logic          sck_i,
  input  wire logic          cs_n_i,
  input  wire logic          si_i,
  output logic               so_o,
  output logic               so_oe_n_o
);

  localparam int unsigned LW = AW + DATA_W;

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  // system clock side
  logic          cs_n_meta_reg;
  logic          cs_n_sync_reg;
  logic          start_meta_reg;
  logic          start_sync_reg;
  logic          start_seen_reg;
  logic          ign_meta_reg;
  logic          ign_sync_reg;
  logic          ign_seen_reg;
  logic          fifo_out_valid;
  logic          fifo_out_ready;
  logic [LW-1:0] fifo_out_data;
  logic          mem_we;

  // serial clock side
  snr_state_t    state_reg;
  snr_state_t    state_next;
  logic [5:0]    bit_cnt_reg;
  logic [31:0]   shift_reg;
  logic          wide_reg;
  logic [AW-1:0] rd_addr_reg;
  logic          ext_meta_reg;
  logic          ext_sync_reg;
  logic          wip_meta_reg;
  logic          wip_sync_reg;
  logic          start_tgl_reg;
  logic [AW-1:0] start_addr_reg;
  logic          ign_tgl_reg;
  logic [7:0]    op_next;
  logic [31:0]   addr_full;
  logic [31:0]   addr_valid;
  logic          op_done;
  logic          addr_done;
  logic          byte_done;
  logic          busy_hit;
  logic          mem_re;
  logic [AW-1:0] mem_raddr;
  logic [7:0]    mem_rdata;

  //////////////////////////////////////////////////////////////////////////////
  // load path: fifo in front of the array write port

  snr_fifo #(
    .WIDTH (LW),
    .DEPTH (DEPTH)
  ) u_load_fifo (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (load_valid_i),
    .in_ready_o  (load_ready_o),
    .in_data_i   ({load_addr_i, load_data_i}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  // chip select crossed into the system clock before any use
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cs_n_meta_reg <= 1'b1;
      cs_n_sync_reg <= 1'b1;
    end else begin
      cs_n_meta_reg <= cs_n_i;
      cs_n_sync_reg <= cs_n_meta_reg;
    end
  end

  // array writes wait while selected, so a read never sees a torn byte
  assign fifo_out_ready = cs_n_sync_reg;
  assign mem_we         = fifo_out_valid && fifo_out_ready;

  // pending writes or an outside erase count as work in progress
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      write_in_progress_flag_o <= 1'b0;
    end else begin
      write_in_progress_flag_o <= fifo_out_valid || array_busy_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // byte array

  snr_array_mem #(
    .DW (DATA_W),
    .AW (AW)
  ) u_array (
    .wclk_i  (clk_i),
    .we_i    (mem_we),
    .waddr_i (fifo_out_data[LW-1:DATA_W]),
    .wdata_i (fifo_out_data[DATA_W-1:0]),
    .rclk_i  (sck_i),
    .re_i    (mem_re),
    .raddr_i (mem_raddr),
    .rdata_o (mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // serial clock side: level synchronisers

  // the serial clock stops between frames; eight opcode edges refill these
  always_ff @(posedge sck_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      wip_meta_reg <= 1'b0;
      wip_sync_reg <= 1'b0;
    end else begin
      ext_meta_reg <= extended_address_mode_bit_i;
      ext_sync_reg <= ext_meta_reg;
      wip_meta_reg <= write_in_progress_flag_o;
      wip_sync_reg <= wip_meta_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // serial clock side: decode

  always_comb begin
    op_next    = {shift_reg[6:0], si_i};
    addr_full  = {shift_reg[30:0], si_i};
    addr_valid = addr_full & (wide_reg ? ADDR_MASK_4B : ADDR_MASK_3B); // [R04] [R05]
    op_done    = (state_reg == SNR_OPCODE) && (bit_cnt_reg == OPCODE_LAST);
    addr_done  = (state_reg == SNR_ADDR)
                 && (bit_cnt_reg == (wide_reg ? ADDR_LAST_4B : ADDR_LAST_3B));
    byte_done  = (state_reg == SNR_DATA) && (bit_cnt_reg[2:0] == BYTE_LAST);
    busy_hit   = op_done && wip_sync_reg
                 && ((op_next == OP_READ) || (op_next == OP_READ_WIDE));
    mem_re     = addr_done || byte_done;
    // first byte read on the last address edge, the next one on each byte end
    mem_raddr  = addr_done ? addr_valid[AW-1:0] : rd_addr_reg + AW'(1); // [R08] [R09]
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SNR_OPCODE: begin
        if (op_done) begin
          if (wip_sync_reg) begin
            state_next = SNR_IGNORE; // [R11]
          end else if ((op_next == OP_READ) || (op_next == OP_READ_WIDE)) begin
            state_next = SNR_ADDR; // [R01]
          end else begin
            state_next = SNR_IGNORE;
          end
        end
      end
      SNR_ADDR: begin
        if (addr_done) begin
          state_next = SNR_DATA;
        end
      end
      SNR_DATA: begin
        state_next = SNR_DATA; // [R06]
      end
      SNR_IGNORE: begin
        state_next = SNR_IGNORE;
      end
      default: begin
        state_next = SNR_IGNORE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // serial clock side: frame state, cleared while chip select is high

  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      state_reg <= SNR_OPCODE; // [R10] [R13]
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_reg <= '0;
    end else if (op_done || addr_done) begin
      bit_cnt_reg <= '0;
    end else if (state_reg == SNR_DATA) begin
      bit_cnt_reg <= {3'h0, bit_cnt_reg[2:0] + BIT_STEP};
    end else if (state_reg != SNR_IGNORE) begin
      bit_cnt_reg <= bit_cnt_reg + CNT_STEP;
    end
  end

  // opcode and address sampled on the rising edge
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      shift_reg <= '0;
    end else if (state_reg == SNR_OPCODE) begin
      shift_reg <= {24'h0, op_next}; // [R03] [R12]
    end else if (state_reg == SNR_ADDR) begin
      shift_reg <= addr_full; // [R04]
    end
  end

  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      wide_reg <= 1'b0;
    end else if (op_done) begin
      wide_reg <= (op_next == OP_READ_WIDE) || ext_sync_reg; // [R02]
    end
  end

  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      rd_addr_reg <= '0;
    end else if (mem_re) begin
      rd_addr_reg <= mem_raddr; // [R08] [R09]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // serial clock side: output on the falling edge

  // select rising forces the pin off at once, even with the clock stopped
  always_ff @(negedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      so_oe_n_o <= 1'b1; // [R10]
      so_o      <= 1'b0;
    end else if (state_reg == SNR_DATA) begin
      so_oe_n_o <= 1'b0;
      so_o      <= mem_rdata[~bit_cnt_reg[2:0]]; // [R07] [R12]
    end else begin
      so_oe_n_o <= 1'b1;
      so_o      <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // events toward the system clock: toggles with steady data

  // toggles survive chip select so that no event is lost between frames
  always_ff @(posedge sck_i or negedge resetn_i) begin
    if (!resetn_i) begin
      start_tgl_reg  <= 1'b0;
      start_addr_reg <= '0;
      ign_tgl_reg    <= 1'b0;
    end else begin
      if (addr_done) begin
        start_tgl_reg  <= ~start_tgl_reg;
        start_addr_reg <= addr_valid[AW-1:0];
      end
      if (busy_hit) begin
        ign_tgl_reg <= ~ign_tgl_reg; // [R11]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      start_meta_reg <= 1'b0;
      start_sync_reg <= 1'b0;
      start_seen_reg <= 1'b0;
      ign_meta_reg   <= 1'b0;
      ign_sync_reg   <= 1'b0;
      ign_seen_reg   <= 1'b0;
    end else begin
      start_meta_reg <= start_tgl_reg;
      start_sync_reg <= start_meta_reg;
      start_seen_reg <= start_sync_reg;
      ign_meta_reg   <= ign_tgl_reg;
      ign_sync_reg   <= ign_meta_reg;
      ign_seen_reg   <= ign_sync_reg;
    end
  end

  // address word is steady for a whole frame, far longer than the sync delay
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      read_start_o   <= 1'b0;
      read_addr_o    <= '0;
      read_ignored_o <= 1'b0;
    end else begin
      read_start_o   <= start_sync_reg ^ start_seen_reg;
      read_ignored_o <= ign_sync_reg ^ ign_seen_reg;
      if (start_sync_reg ^ start_seen_reg) begin
        read_addr_o <= start_addr_reg;
      end
    end
  end

endmodule

`default_nettype wire

// ==== sim/snr_normal_read_properties.sv ====
// port checker for the serial normal read block
`timescale 1ns/100ps
`default_nettype none
module snr_normal_read_properties
  import snr_pkg::*;
#(
  parameter int unsigned AW = ARRAY_AW
) (
  input wire logic          clk_i,
  input wire logic          resetn_i,
  input wire logic          load_valid_i,
  input wire logic          load_ready_o,
  input wire logic          extended_address_mode_bit_i,
  input wire logic          write_in_progress_flag_o,
  input wire logic          read_ignored_o,
  input wire logic          read_start_o,
  input wire logic          sck_i,
  input wire logic          cs_n_i,
  input wire logic          si_i,
  input wire logic          so_o,
  input wire logic          so_oe_n_o
);
  logic [5:0] rises;
  logic [7:0] op;
  ////////////////////////////////////////////////////////////////
  // rises since select; saturates so long reads stay quiet
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      rises <= 6'h00;
      op    <= 8'h00;
    end else begin
      if (rises != 6'h3f) rises <= rises + CNT_STEP;
      if (rises < 6'h08) op <= {op[6:0], si_i};
    end
  end
  ////////////////////////////////////////////////////////////////
  property p_oe_off;
    @(posedge clk_i) disable iff (!resetn_i) cs_n_i |-> so_oe_n_o && !so_o;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("so driven while deselected");
  property p_so_fall;
    @(posedge clk_i) disable iff (!resetn_i) $changed(so_o) |-> !sck_i;
  endproperty
  a_so_fall: assert property (p_so_fall)
    else $error("so changed while sck high");
  property p_early;
    @(posedge sck_i) disable iff (cs_n_i || !resetn_i) !so_oe_n_o |-> rises >= 6'h20;
  endproperty
  a_early: assert property (p_early)
    else $error("output before address end");
  property p_narrow;
    @(posedge sck_i) disable iff (cs_n_i || !resetn_i)
      rises == 6'h20 && op == OP_READ && !extended_address_mode_bit_i
      && !write_in_progress_flag_o |-> !so_oe_n_o;
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("three byte read gave no output");
  property p_wide;
    @(posedge sck_i) disable iff (cs_n_i || !resetn_i)
      op == OP_READ_WIDE && !write_in_progress_flag_o
      |-> (rises < 6'h28) == so_oe_n_o;
  endproperty
  a_wide: assert property (p_wide)
    else $error("wide read output at wrong bit");
  property p_unknown;
    @(posedge sck_i) disable iff (cs_n_i || !resetn_i)
      rises > 6'h08 && op != OP_READ && op != OP_READ_WIDE |-> so_oe_n_o;
  endproperty
  a_unknown: assert property (p_unknown)
    else $error("unknown opcode produced output");
  property p_ign;
    @(posedge clk_i) disable iff (!resetn_i)
      read_ignored_o |-> write_in_progress_flag_o && !read_start_o ##1 !read_ignored_o;
  endproperty
  a_ign: assert property (p_ign)
    else $error("bad ignore pulse");
  property p_take;
    @(posedge clk_i) disable iff (!resetn_i)
      load_valid_i && load_ready_o |-> ##2 write_in_progress_flag_o;
  endproperty
  a_take: assert property (p_take)
    else $error("busy flag missing after load");
  c_read: cover property (@(posedge clk_i) disable iff (!resetn_i) read_start_o);
  c_ign: cover property (@(posedge clk_i) disable iff (!resetn_i) read_ignored_o);
  c_full: cover property (@(posedge clk_i) disable iff (!resetn_i)
    load_valid_i && !load_ready_o);
endmodule
bind snr_normal_read snr_normal_read_properties #(.AW(AW)) u_props (.*);
`default_nettype wire

// ==== sim/snr_host_model.sv ====
// host spi controller sending normal read frames, mode 0
`timescale 1ns/100ps
`default_nettype none
module snr_host_model (
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o,
  input  wire logic so_i,
  input  wire logic so_oe_n_i
);
  logic [7:0] got[$];
  logic       oe_seen;
  logic [7:0] shift;
  initial begin
    sck_o   = 1'b0;
    cs_n_o  = 1'b1;
    si_o    = 1'b0;
    oe_seen = 1'b0;
    shift   = 8'h00;
  end
  // 48 ns period, well under the top rate; si set while sck low
  task automatic tick(input logic b);
    si_o = b;
    #24 sck_o = 1'b1;
    if (so_oe_n_i === 1'b0) oe_seen = 1'b1;
    shift = {shift[6:0], so_i};
    #24 sck_o = 1'b0;
  endtask
  // offset keeps select edges off the system clock edges
  task automatic hold(input logic sel);
    #7 cs_n_o = !sel;
  endtask
  task automatic frame(input logic [7:0] op, input logic [31:0] a,
                       input int na, input int nb);
    got.delete();
    oe_seen = 1'b0;
    #7 cs_n_o = 1'b0;
    #24;
    for (int i = 7; i >= 0; i--) tick(op[i]);
    for (int i = na - 1; i >= 0; i--) tick(a[i]);
    for (int j = 0; j < 8 * nb; j++) begin
      tick(!si_o);
      if (j % 8 == 7) got.push_back(shift);
    end
    #24 cs_n_o = 1'b1;
    si_o = !si_o;
    #48;
  endtask
endmodule
`default_nettype wire

// ==== sim/snr_normal_read_tb.sv ====
// self-checking bench for the serial normal read block
`timescale 1ns/100ps
`default_nettype none
module snr_normal_read_tb;
  import snr_pkg::*;
  localparam int unsigned TAW = 10;
  logic           clk_i, resetn_i, load_valid_i, load_ready_o, array_busy_i, ext_i;
  logic           wip_o, read_start_o, read_ignored_o, sck_i, cs_n_i, si_i, so_o, so_oe_n_o;
  logic [TAW-1:0] load_addr_i, read_addr_o;
  logic [7:0]     load_data_i;
  logic [7:0]     mem [1024];
  logic [31:0]    r;
  int             seed, fails, checked, starts, ignores, mark;
  snr_normal_read #(.AW(TAW), .DEPTH(FIFO_WORDS)) u_snr_normal_read (
    .clk_i, .resetn_i, .load_valid_i, .load_ready_o, .load_addr_i, .load_data_i,
    .array_busy_i, .extended_address_mode_bit_i(ext_i), .write_in_progress_flag_o(wip_o),
    .read_start_o, .read_addr_o, .read_ignored_o, .sck_i, .cs_n_i, .si_i, .so_o, .so_oe_n_o
  );
  snr_host_model u_snr_host_model (
    .sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i), .so_i(so_o), .so_oe_n_i(so_oe_n_o)
  );
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = !clk_i;
  end
  always @(posedge clk_i) begin
    if (read_start_o === 1'b1) starts++;
    if (read_ignored_o === 1'b1) ignores++;
  end
  ////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [7:0] expb(input logic [31:0] a, input int i);
    logic [TAW-1:0] x;
    x = a[TAW-1:0] + TAW'(i);
    return mem[x];
  endfunction
  // leaves valid up so back to back loads need no gap
  task automatic ld(input logic [TAW-1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    load_valid_i <= 1'b1;
    load_addr_i  <= a;
    load_data_i  <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (load_ready_o !== 1'b1 && n < 100);
    if (n >= 100) begin
      fails++;
      close_out();
    end
    mem[a] = d;
  endtask
  task automatic settle;
    int n;
    n = 0;
    repeat (3) @(posedge clk_i);
    while (wip_o !== 1'b0 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk("wip", wip_o, 1'b0);
    // a flag stuck high means a hung drain: stop here
    if (wip_o !== 1'b0) close_out();
  endtask
  task automatic rd(input logic [7:0] op, input logic e, input logic [31:0] a, input int nb);
    int s;
    ext_i <= e;
    @(posedge clk_i);
    s = starts;
    u_snr_host_model.frame(op, a, (op == OP_READ_WIDE || e) ? 32 : 24, nb);
    chk("bytes", u_snr_host_model.got.size(), nb);
    for (int i = 0; i < nb && i < u_snr_host_model.got.size(); i++)
      chk("data", u_snr_host_model.got[i], expb(a, i));
    chk("starts", starts - s, 1);
    chk("addr", read_addr_o, a[TAW-1:0]);
  endtask
  task automatic quiet(input logic [7:0] op, input int na, input int nb);
    ext_i <= 1'b0;
    @(posedge clk_i);
    u_snr_host_model.frame(op, 32'h0000_0005, na, nb);
    chk("oe", u_snr_host_model.oe_seen, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    seed = 95190;
    fails = 0;
    checked = 0;
    starts = 0;
    ignores = 0;
    resetn_i = 1'b0;
    load_valid_i = 1'b0;
    load_addr_i = '0;
    load_data_i = 8'h00;
    array_busy_i = 1'b0;
    ext_i = 1'b0;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    // writes pause while selected, so the fifo must refuse at 32
    u_snr_host_model.hold(1'b1);
    for (int i = 0; i < 32; i++)
      ld(i < 16 ? TAW'(i) : TAW'(i + 992), 8'($random(seed)));
    load_addr_i <= 10'h010;
    repeat (3) @(posedge clk_i);
    chk("full", load_ready_o, 1'b0);
    u_snr_host_model.hold(1'b0);
    ld(10'h010, 8'h5a);
    load_valid_i <= 1'b0;
    settle();
    rd(OP_READ, 1'b0, 32'h00a5_53fe, 4);
    rd(OP_READ, 1'b1, 32'hfe7c_0005, 2);
    rd(OP_READ_WIDE, 1'b0, 32'h9bd3_ec0a, 2);
    rd(OP_READ_WIDE, 1'b1, 32'h01ff_fbff, 1);
    for (int k = 0; k < 6; k++) begin
      r = $random(seed);
      rd(r[0] ? OP_READ : OP_READ_WIDE, r[1], {r[31:10], 10'h3f8 + {6'h00, r[5:2]}},
         1 + r[7:6]);
    end
    quiet(OP_READ, 12, 0);
    rd(OP_READ, 1'b0, 32'h0000_0003, 1);
    quiet(8'h0b, 24, 1);
    array_busy_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    mark = ignores;
    quiet(OP_READ, 24, 1);
    chk("ignored", ignores - mark, 1);
    chk("busy", wip_o, 1'b1);
    array_busy_i <= 1'b0;
    settle();
    ld(10'h005, 8'hc3);
    load_valid_i <= 1'b0;
    settle();
    rd(OP_READ_WIDE, 1'b0, 32'h0000_0005, 2);
    close_out();
  end
endmodule
`default_nettype wire
